//--- hdl/ocpg_pkg.sv
// package: constants and types for the output compare pulse generator
package ocpg_pkg;
    // register offsets
    localparam logic [3:0] OCPG_ADDR_CTRL = 4'h0;
    localparam logic [3:0] OCPG_ADDR_PRI = 4'h1;
    localparam logic [3:0] OCPG_ADDR_SEC = 4'h2;
    localparam logic [3:0] OCPG_ADDR_TCTL0 = 4'h3;
    localparam logic [3:0] OCPG_ADDR_TCTL1 = 4'h4;
    localparam logic [3:0] OCPG_ADDR_PER0 = 4'h5;
    localparam logic [3:0] OCPG_ADDR_PER1 = 4'h6;
    localparam logic [3:0] OCPG_ADDR_CNT0 = 4'h7;
    localparam logic [3:0] OCPG_ADDR_CNT1 = 4'h8;
    localparam logic [3:0] OCPG_ADDR_STAT = 4'h9;
    localparam logic [3:0] OCPG_ADDR_MASK = 4'hA;
    localparam logic [3:0] OCPG_ADDR_PIN = 4'hB;
    // control field positions
    localparam int OCPG_MODE_LSB = 0;
    localparam int OCPG_TSEL_BIT = 3;
    localparam int OCPG_RUN_BIT = 15;
    localparam int OCPG_FLAG_BIT = 0;
    // mode codes
    localparam logic [2:0] OCPG_MODE_OFF = 3'h0;
    localparam logic [2:0] OCPG_MODE_SINGLE = 3'h4;
    localparam logic [2:0] OCPG_MODE_CONT = 3'h5;
    // reset values
    localparam logic [15:0] OCPG_RST_WORD = 16'h0000;
    localparam logic [15:0] OCPG_RST_PER = 16'hFFFF;
    localparam logic [15:0] OCPG_CNT_ZERO = 16'h0000;
    localparam logic [15:0] OCPG_CNT_ONE = 16'h0001;

    // pulse sequencer states, gray along idle -> wait_rise -> high -> done
    typedef enum logic [1:0] {
        OCPG_IDLE = 2'b00,
        OCPG_WAIT_RISE = 2'b01,
        OCPG_HIGH = 2'b11,
        OCPG_DONE = 2'b10
    } ocpg_state_t;
endpackage

//--- hdl/ocpg_timer.sv
// file: one free-running timer with period reset
`timescale 1ns/1ps
`default_nettype none
module ocpg_timer
    import ocpg_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic run,
    input wire logic [WIDTH-1:0] period,
    input wire logic clr,
    output logic [WIDTH-1:0] count
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } ocpg_tmr_t;

    ocpg_tmr_t st_r;
    ocpg_tmr_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (clr) begin
            st_nxt.cnt = '0;
        end else if (run) begin
            if (st_r.cnt == period) begin
                st_nxt.cnt = '0;
            end else begin
                st_nxt.cnt = st_r.cnt + WIDTH'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign count = st_r.cnt;
endmodule
`default_nettype wire

//--- hdl/ocpg_top.sv
// file: output compare channel with two timers and register port
`timescale 1ns/1ps
`default_nettype none
module ocpg_top
    import ocpg_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    output logic compare_output_pin,
    output logic irq
);
    // ***************************************************************
    // state
    // ***************************************************************
    typedef struct packed {
        logic [2:0] compare_mode_field;
        logic timer_source_select;
        logic [WIDTH-1:0] primary_compare_value;
        logic [WIDTH-1:0] secondary_compare_value;
        logic [1:0] timer_run_bit;
        logic [1:0][WIDTH-1:0] timer_period_value;
        logic [WIDTH-1:0] last_cnt;
        logic cnt_valid;
        logic pri_hit;
        logic sec_hit;
        ocpg_state_t state;
        logic pin;
        logic compare_event_flag;
        logic compare_event_irq_enable;
        logic irq;
        logic [15:0] rdata;
    } ocpg_reg_t;

    ocpg_reg_t st_r;
    ocpg_reg_t st_nxt;
    logic [1:0][WIDTH-1:0] timer_count;
    logic [1:0] tmr_clr;
    logic [WIDTH-1:0] sel_cnt;
    logic [15:0] wd;

    // ***************************************************************
    // timers
    // ***************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tmr
            ocpg_timer #(.WIDTH(WIDTH)) u_tmr (
                .mclk(mclk),
                .nrst(nrst),
                .run(st_r.timer_run_bit[gi]),
                .period(st_r.timer_period_value[gi]),
                .clr(tmr_clr[gi]),
                .count(timer_count[gi])
            );
            // writing a count register clears it
            assign tmr_clr[gi] = wr &&
                (addr == (gi == 0 ? OCPG_ADDR_CNT0 : OCPG_ADDR_CNT1));
        end
    endgenerate

    assign sel_cnt = timer_count[st_r.timer_source_select];
    assign wd = wdata;

    // ***************************************************************
    // next state
    // ***************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = OCPG_RST_WORD;
        st_nxt.pri_hit = 1'b0;
        st_nxt.sec_hit = 1'b0;
        st_nxt.last_cnt = sel_cnt;
        st_nxt.cnt_valid = 1'b1;
        // compare only when the count moved or first seen
        if (!st_r.cnt_valid || sel_cnt != st_r.last_cnt) begin
            st_nxt.pri_hit = (sel_cnt == st_r.primary_compare_value);
            st_nxt.sec_hit = (sel_cnt == st_r.secondary_compare_value);
        end

        // pulse sequencer
        case (st_r.state)
            OCPG_IDLE: begin
                st_nxt.pin = 1'b0;
            end
            OCPG_WAIT_RISE: begin
                if (st_r.pri_hit) begin
                    st_nxt.pin = 1'b1;
                    st_nxt.state = OCPG_HIGH;
                end
            end
            OCPG_HIGH: begin
                if (st_r.sec_hit) begin
                    st_nxt.pin = 1'b0;
                    if (st_r.compare_mode_field == OCPG_MODE_CONT) begin
                        st_nxt.state = OCPG_WAIT_RISE;
                    end else begin
                        st_nxt.state = OCPG_DONE;
                    end
                end
            end
            OCPG_DONE: begin
                st_nxt.pin = 1'b0;
            end
            default: begin
                st_nxt.state = OCPG_IDLE;
                st_nxt.pin = 1'b0;
            end
        endcase

        // register writes
        if (wr) begin
            case (addr)
                OCPG_ADDR_CTRL: begin
                    st_nxt.compare_mode_field = wd[OCPG_MODE_LSB +: 3];
                    st_nxt.timer_source_select = wd[OCPG_TSEL_BIT];
                    st_nxt.pin = 1'b0;
                    // timer left alone on rearm
                    if (wd[OCPG_MODE_LSB +: 3] == OCPG_MODE_SINGLE ||
                        wd[OCPG_MODE_LSB +: 3] == OCPG_MODE_CONT) begin
                        st_nxt.state = OCPG_WAIT_RISE;
                    end else begin
                        st_nxt.state = OCPG_IDLE;
                    end
                end
                OCPG_ADDR_PRI: st_nxt.primary_compare_value = wd[WIDTH-1:0];
                OCPG_ADDR_SEC: st_nxt.secondary_compare_value = wd[WIDTH-1:0];
                OCPG_ADDR_TCTL0: st_nxt.timer_run_bit[0] = wd[OCPG_RUN_BIT];
                OCPG_ADDR_TCTL1: st_nxt.timer_run_bit[1] = wd[OCPG_RUN_BIT];
                OCPG_ADDR_PER0: st_nxt.timer_period_value[0] = wd[WIDTH-1:0];
                OCPG_ADDR_PER1: st_nxt.timer_period_value[1] = wd[WIDTH-1:0];
                OCPG_ADDR_STAT: begin
                    if (wd[OCPG_FLAG_BIT]) begin
                        st_nxt.compare_event_flag = 1'b0;
                    end
                end
                OCPG_ADDR_MASK: begin
                    st_nxt.compare_event_irq_enable = wd[OCPG_FLAG_BIT];
                end
                default: begin
                end
            endcase
        end

        // flag set wins over a same-cycle clear
        if (st_r.state == OCPG_HIGH && st_r.sec_hit) begin
            st_nxt.compare_event_flag = 1'b1;
        end
        st_nxt.irq = st_nxt.compare_event_flag &&
            st_nxt.compare_event_irq_enable;

        // reads, data next cycle
        if (rd) begin
            case (addr)
                OCPG_ADDR_CTRL: begin
                    st_nxt.rdata[OCPG_MODE_LSB +: 3] = st_r.compare_mode_field;
                    st_nxt.rdata[OCPG_TSEL_BIT] = st_r.timer_source_select;
                end
                OCPG_ADDR_PRI: st_nxt.rdata[WIDTH-1:0] =
                    st_r.primary_compare_value;
                OCPG_ADDR_SEC: st_nxt.rdata[WIDTH-1:0] =
                    st_r.secondary_compare_value;
                OCPG_ADDR_TCTL0: st_nxt.rdata[OCPG_RUN_BIT] =
                    st_r.timer_run_bit[0];
                OCPG_ADDR_TCTL1: st_nxt.rdata[OCPG_RUN_BIT] =
                    st_r.timer_run_bit[1];
                OCPG_ADDR_PER0: st_nxt.rdata[WIDTH-1:0] =
                    st_r.timer_period_value[0];
                OCPG_ADDR_PER1: st_nxt.rdata[WIDTH-1:0] =
                    st_r.timer_period_value[1];
                OCPG_ADDR_CNT0: st_nxt.rdata[WIDTH-1:0] = timer_count[0];
                OCPG_ADDR_CNT1: st_nxt.rdata[WIDTH-1:0] = timer_count[1];
                OCPG_ADDR_STAT: st_nxt.rdata[OCPG_FLAG_BIT] =
                    st_r.compare_event_flag;
                OCPG_ADDR_MASK: st_nxt.rdata[OCPG_FLAG_BIT] =
                    st_r.compare_event_irq_enable;
                OCPG_ADDR_PIN: st_nxt.rdata[OCPG_FLAG_BIT] = st_r.pin;
                default: st_nxt.rdata = OCPG_RST_WORD;
            endcase
        end
    end

    // ***************************************************************
    // registers
    // ***************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
            st_r.timer_period_value <= {2{OCPG_RST_PER[WIDTH-1:0]}};
            st_r.state <= OCPG_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign compare_output_pin = st_r.pin;
    assign irq = st_r.irq;
endmodule
`default_nettype wire

//--- sim/ocpg_sva.sv
// checker: port-level assertions for the compare channel
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// compare channel checker
// ****************************************
module ocpg_sva
    import ocpg_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic compare_output_pin,
    input wire logic irq
);
    logic cw;
    logic sw;
    logic [2:0] mode_r;
    logic mask_r, pin_q, cw_q, done_r;
    assign cw = wr && addr == OCPG_ADDR_CTRL;
    assign sw = wr && (addr == OCPG_ADDR_STAT || addr == OCPG_ADDR_MASK);
    // shadow of mode and mask, and single pulse completion
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mode_r <= OCPG_MODE_OFF;
            mask_r <= 1'b0;
            pin_q <= 1'b0;
            cw_q <= 1'b0;
            done_r <= 1'b0;
        end else begin
            if (cw) mode_r <= wdata[2:0];
            if (wr && addr == OCPG_ADDR_MASK) mask_r <= wdata[0];
            pin_q <= compare_output_pin;
            cw_q <= cw;
            if (cw) done_r <= 1'b0;
            else if (mode_r == OCPG_MODE_SINGLE && pin_q &&
                     !compare_output_pin && !cw_q) done_r <= 1'b1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_arm(logic [2:0] code);
        cw && wdata[2:0] == code;
    endsequence
    sequence s_trail;
        $fell(compare_output_pin) && !$past(cw);
    endsequence
    single_arm_low_a: assert property (
        s_arm(OCPG_MODE_SINGLE) |=> !compare_output_pin)
        else $error("pin not low after single arm");
    cont_arm_low_a: assert property (
        s_arm(OCPG_MODE_CONT) |=> !compare_output_pin)
        else $error("pin not low after continuous arm");
    off_mode_low_a: assert property (
        mode_r != OCPG_MODE_SINGLE && mode_r != OCPG_MODE_CONT
        |-> !compare_output_pin) else $error("pin high while off");
    single_hold_a: assert property (done_r |-> !compare_output_pin)
        else $error("extra pulse after single pulse");
    flag_irq_a: assert property (
        s_trail ##0 (mask_r && $past(mask_r)) |-> ##[0:1] irq)
        else $error("trailing match raised no irq");
    irq_masked_a: assert property (!mask_r && !$past(mask_r) |-> !irq)
        else $error("irq while masked");
    irq_sticky_a: assert property (irq && !sw && !$past(sw) |=> irq)
        else $error("irq dropped without clear");
    rd_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data outside read slot");
    pin_read_a: assert property (rd && addr == OCPG_ADDR_PIN
        |=> rdata == {15'h0000, $past(compare_output_pin)})
        else $error("pin status read wrong");
endmodule
bind ocpg_top ocpg_sva u_sva (.mclk(mclk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .compare_output_pin(compare_output_pin), .irq(irq));
`default_nettype wire

//--- sim/ocpg_load.sv
// load model: measures pulses seen on the compare pin
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// pulse meter
// ****************************************
module ocpg_load (
    input wire logic mclk,
    input wire logic pin,
    output logic [15:0] n_rise,
    output logic [15:0] hi_w,
    output logic [15:0] per_w
);
    logic [15:0] hi_c, per_c;
    logic pin_q;
    initial begin
        {n_rise, hi_w, per_w, hi_c, per_c} = '0;
        pin_q = 1'b0;
    end
    always @(posedge mclk) begin
        pin_q <= pin;
        hi_c <= (pin === 1'b1) ? hi_c + 16'h0001 : 16'h0000;
        per_c <= per_c + 16'h0001;
        if (pin === 1'b1 && !pin_q) begin
            n_rise <= n_rise + 16'h0001;
            per_w <= per_c;
            per_c <= 16'h0001;
        end
        if (pin === 1'b0 && pin_q) hi_w <= hi_c;
    end
endmodule
`default_nettype wire

//--- sim/ocpg_tb_top.sv
// testbench: drives the register port and checks the compare pin
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// compare channel testbench
// ****************************************
module ocpg_tb_top;
    import ocpg_pkg::*;
    logic mclk, nrst, wr, rd, pin, irq;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, n_rise, hi_w, per_w, n0;
    logic [31:0] lf;
    int n_mismatch, compares, cyc;
    ocpg_top #(.WIDTH(16)) uut (.mclk(mclk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .compare_output_pin(pin), .irq(irq));
    ocpg_load u_load (.mclk(mclk), .pin(pin), .n_rise(n_rise),
        .hi_w(hi_w), .per_w(per_w));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic acc(input logic [3:0] a, input logic [15:0] d,
                       input logic w, input logic r, input logic [15:0] e);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= r;
        @(posedge mclk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        if (r) check("rdata", e, rdata);
        @(posedge mclk);
    endtask
    task automatic irq_is(input logic [15:0] e);
        repeat (2) @(negedge mclk);
        check("irq", e, {15'h0000, irq});
        @(posedge mclk);
    endtask
    task automatic run(input logic [2:0] m, input logic ts);
        logic [15:0] pri, sec, per;
        repeat (9) lf = lfsr(lf);
        pri = {13'h0000, lf[2:0]} + 16'h0001;
        sec = pri + {13'h0000, lf[5:3]} + 16'h0001;
        per = sec + {13'h0000, lf[8:6]};
        acc(OCPG_ADDR_PRI, pri, 1'b1, 1'b0, 16'h0000);
        acc(OCPG_ADDR_SEC, sec, 1'b1, 1'b0, 16'h0000);
        acc(ts ? OCPG_ADDR_PER1 : OCPG_ADDR_PER0, per, 1'b1, 1'b0, 0);
        acc(ts ? OCPG_ADDR_PER0 : OCPG_ADDR_PER1, 16'h0040, 1'b1, 1'b0, 0);
        acc(ts ? OCPG_ADDR_CNT1 : OCPG_ADDR_CNT0, 0, 1'b1, 1'b0, 0);
        acc(OCPG_ADDR_CTRL, {12'h000, ts, m}, 1'b1, 1'b0, 0);
        n0 = n_rise;
        acc(OCPG_ADDR_TCTL0, 16'h8000, 1'b1, 1'b0, 16'h0000);
        acc(OCPG_ADDR_TCTL1, 16'h8000, 1'b1, 1'b0, 16'h0000);
        acc(OCPG_ADDR_CTRL, 16'h0000, 1'b0, 1'b1, {12'h000, ts, m});
        acc(OCPG_ADDR_PRI, 16'h0000, 1'b0, 1'b1, pri);
        acc(OCPG_ADDR_SEC, 16'h0000, 1'b0, 1'b1, sec);
        acc(OCPG_ADDR_TCTL1, 16'h0000, 1'b0, 1'b1, 16'h8000);
        acc(ts ? OCPG_ADDR_PER1 : OCPG_ADDR_PER0, 0, 1'b0, 1'b1, per);
        repeat (3 * per + 6) @(posedge mclk);
        if (m == OCPG_MODE_SINGLE) begin
            check("pulses", n0 + 16'h0001, n_rise);
        end else begin
            check("period", per + 16'h0001, per_w);
        end
        check("width", sec - pri, hi_w);
    endtask
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        {nrst, wr, rd, addr, wdata} = '0;
        {n_mismatch, compares, cyc} = '0;
        lf = 32'hB240;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        acc(OCPG_ADDR_PER0, 16'h0000, 1'b0, 1'b1, OCPG_RST_PER);
        acc(OCPG_ADDR_CTRL, 16'h0000, 1'b0, 1'b1, OCPG_RST_WORD);
        acc(4'hF, 16'h1234, 1'b1, 1'b0, 16'h0000);
        acc(4'hF, 16'h0000, 1'b0, 1'b1, 16'h0000);
        run(OCPG_MODE_SINGLE, 1'b0);
        irq_is(16'h0000);
        acc(OCPG_ADDR_STAT, 16'h0000, 1'b0, 1'b1, 16'h0001);
        acc(OCPG_ADDR_MASK, 16'h0001, 1'b1, 1'b0, 16'h0000);
        irq_is(16'h0001);
        acc(OCPG_ADDR_MASK, 16'h0000, 1'b0, 1'b1, 16'h0001);
        acc(OCPG_ADDR_STAT, 16'h0001, 1'b1, 1'b0, 16'h0000);
        irq_is(16'h0000);
        n0 = n_rise;
        acc(OCPG_ADDR_CTRL, {13'h0000, OCPG_MODE_SINGLE}, 1'b1, 1'b0, 0);
        repeat (80) @(posedge mclk);
        check("rearm", n0 + 16'h0001, n_rise);
        irq_is(16'h0001);
        run(OCPG_MODE_CONT, 1'b1);
        run(OCPG_MODE_CONT, 1'b0);
        acc(OCPG_ADDR_STAT, 16'h0001, 1'b1, 1'b0, 16'h0000);
        // pin status read while the train runs, high and low
        repeat (40) begin
            addr <= OCPG_ADDR_PIN;
            rd <= 1'b1;
            @(posedge mclk);
            rd <= 1'b0;
            #1;
            check("pin", {15'h0000, u_load.pin_q}, rdata);
            @(posedge mclk);
        end
        acc(OCPG_ADDR_STAT, 16'h0000, 1'b0, 1'b1, 16'h0001);
        for (int m = 0; m < 8; m++) begin
            acc(OCPG_ADDR_CTRL, 16'(m), 1'b1, 1'b0, 16'h0000);
        end
        acc(OCPG_ADDR_PIN, 16'h0000, 1'b0, 1'b1, 16'h0000);
        acc(OCPG_ADDR_TCTL0, 16'h0000, 1'b1, 1'b0, 16'h0000);
        acc(OCPG_ADDR_CNT0, 16'h0000, 1'b1, 1'b0, 16'h0000);
        acc(OCPG_ADDR_CNT0, 16'h0000, 1'b0, 1'b1, OCPG_CNT_ZERO);
        acc(OCPG_ADDR_TCTL0, 16'h0000, 1'b0, 1'b1, 16'h0000);
        // second reset in mid-run, timer1 still counting
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        n0 = n_rise;
        @(posedge mclk);
        acc(OCPG_ADDR_PER1, 16'h0000, 1'b0, 1'b1, OCPG_RST_PER);
        acc(OCPG_ADDR_CNT1, 16'h0000, 1'b0, 1'b1, OCPG_CNT_ZERO);
        acc(OCPG_ADDR_STAT, 16'h0000, 1'b0, 1'b1, OCPG_RST_WORD);
        check("irq", 16'h0000, {15'h0000, irq});
        check("quiet", n0, n_rise);
        end_sim();
    end
endmodule
`default_nettype wire
